//--- hw/sswd_pkg.sv
package sswd_pkg;

    // ==========================================================
    // timebase
    // ==========================================================
    localparam int unsigned CLK_FREQ_MHZ = 10; // 100 ns period

    // ==========================================================
    // watchdog period options, in microseconds as printed
    // ==========================================================
    localparam int unsigned WD_PERIOD_US_OPT0 = 6200;
    localparam int unsigned WD_PERIOD_US_OPT1 = 102000;
    localparam int unsigned WD_PERIOD_US_OPT2 = 1600000;
    localparam int unsigned WD_PERIOD_US_OPT3 = 25600000;
    localparam int unsigned WD_SEL_DEFAULT = 0;

    // ==========================================================
    // reset hold period, a plain default since no figure is fixed
    // ==========================================================
    localparam int unsigned RESET_TIMEOUT_US = 200000;
    localparam int unsigned RESET_TIMEOUT_CYCLES = RESET_TIMEOUT_US * CLK_FREQ_MHZ;

    // ==========================================================
    // counter width and reset values
    // ==========================================================
    localparam int unsigned TIMER_WIDTH = 32;
    localparam logic LOW_LINE_RESET_VAL = 1'b0; // warn until the supply is known
    localparam logic ACTIVITY_RESET_VAL = 1'b0;

    // ==========================================================
    // supervisor states, gray along power-up then watchdog trip
    // ==========================================================
    typedef enum logic [1:0] {
        ST_RESET = 2'h0,
        ST_HOLD = 2'h1,
        ST_RUN = 2'h3,
        ST_WDHOLD = 2'h2
    } sswd_state_type;

    // watchdog period in clock cycles for an option code
    function automatic int unsigned wd_period_cycles(input int unsigned sel);
        int unsigned us;
        us = WD_PERIOD_US_OPT0;
        case (sel)
            1: us = WD_PERIOD_US_OPT1;
            2: us = WD_PERIOD_US_OPT2;
            3: us = WD_PERIOD_US_OPT3;
            default: us = WD_PERIOD_US_OPT0;
        endcase
        return us * CLK_FREQ_MHZ;
    endfunction : wd_period_cycles

endpackage : sswd_pkg

//--- hw/sswd_timer.sv
// saturating up-counter; clear wins over counting
module sswd_timer #(
    parameter int unsigned WIDTH = sswd_pkg::TIMER_WIDTH,
    parameter logic [WIDTH-1:0] LIMIT = WIDTH'(sswd_pkg::RESET_TIMEOUT_CYCLES)
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_clear,
    output logic [WIDTH-1:0] o_count,
    output logic o_done
);

    logic [WIDTH-1:0] count_r;
    logic [WIDTH-1:0] count_nxt;

    // ==========================================================
    // count
    // ==========================================================
    // stop at the limit so a long stall cannot wrap and look fresh
    always_comb begin
        count_nxt = count_r;
        if (i_clear) begin
            count_nxt = '0;
        end else if (count_r != LIMIT) begin
            count_nxt = count_r + WIDTH'(1);
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            count_r <= '0;
        end else begin
            count_r <= count_nxt;
        end
    end

    assign o_count = count_r;
    assign o_done = (count_r == LIMIT);

endmodule : sswd_timer

//--- hw/sswd_supervisor.sv
module sswd_supervisor #(
    parameter bit RESET_ACTIVE_HIGH = 1'b0,
    parameter int unsigned WD_SEL = sswd_pkg::WD_SEL_DEFAULT,
    parameter int unsigned WD_CYCLES = sswd_pkg::wd_period_cycles(WD_SEL),
    parameter int unsigned RESET_CYCLES = sswd_pkg::RESET_TIMEOUT_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_supply_ok,
    input wire logic i_above_low_line,
    input wire logic i_above_low_line_hyst,
    input wire logic i_watchdog_activity_input,
    output logic o_sys_reset,
    output logic o_low_line_warning
);

    localparam int unsigned W = sswd_pkg::TIMER_WIDTH;
    localparam logic RST_OUT_INIT = RESET_ACTIVE_HIGH;

    // reset is asserted in every state except normal running
    function automatic logic reset_asserted(input sswd_pkg::sswd_state_type st);
        return (st != sswd_pkg::ST_RUN);
    endfunction : reset_asserted

    // level driven on the pin for an asserted flag
    function automatic logic reset_level(input logic asserted);
        return RESET_ACTIVE_HIGH ? asserted : !asserted;
    endfunction : reset_level

    sswd_pkg::sswd_state_type state_r;
    sswd_pkg::sswd_state_type state_nxt;
    logic sys_reset_r;
    logic sys_reset_nxt;
    logic low_line_r;
    logic low_line_nxt;
    logic activity_prev_r;
    logic activity_prev_nxt;
    logic activity_edge;
    logic hold_clear;
    logic hold_done;
    logic [W-1:0] hold_count;
    logic wd_clear;
    logic wd_done;
    logic [W-1:0] wd_count;

    // ==========================================================
    // timers
    // ==========================================================
    // hold timer only runs while a release is pending
    assign hold_clear = (state_r != sswd_pkg::ST_HOLD) && (state_r != sswd_pkg::ST_WDHOLD);

    sswd_timer #(
        .WIDTH(W),
        .LIMIT(W'(RESET_CYCLES))
    ) u_hold_timer (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_clear(hold_clear),
        .o_count(hold_count),
        .o_done(hold_done)
    );

    // any edge on the activity line, taken as synchronous
    assign activity_edge = i_watchdog_activity_input ^ activity_prev_r;
    // watchdog sits at zero outside running so it restarts clean
    assign wd_clear = (state_r != sswd_pkg::ST_RUN) || activity_edge;

    sswd_timer #(
        .WIDTH(W),
        .LIMIT(W'(WD_CYCLES))
    ) u_wd_timer (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_clear(wd_clear),
        .o_count(wd_count),
        .o_done(wd_done)
    );

    // ==========================================================
    // supervisor state
    // ==========================================================
    // a low supply overrides every other cause and restarts the hold
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            sswd_pkg::ST_RESET: begin
                if (i_supply_ok) begin
                    state_nxt = sswd_pkg::ST_HOLD;
                end
            end
            sswd_pkg::ST_HOLD: begin
                if (hold_done) begin
                    state_nxt = sswd_pkg::ST_RUN;
                end
            end
            sswd_pkg::ST_RUN: begin
                if (wd_done) begin
                    state_nxt = sswd_pkg::ST_WDHOLD;
                end
            end
            sswd_pkg::ST_WDHOLD: begin
                if (hold_done) begin
                    state_nxt = sswd_pkg::ST_RUN;
                end
            end
        endcase
        if (!i_supply_ok) begin
            state_nxt = sswd_pkg::ST_RESET;
        end
    end

    // ==========================================================
    // outputs and edge history
    // ==========================================================
    // the reset output is taken from the next state so the pin has no extra lag
    always_comb begin
        sys_reset_nxt = reset_level(reset_asserted(state_nxt));
        activity_prev_nxt = i_watchdog_activity_input;
        low_line_nxt = low_line_r;
        if (!i_above_low_line) begin
            low_line_nxt = 1'b0;
        end else if (i_above_low_line_hyst) begin
            low_line_nxt = 1'b1;
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_r <= sswd_pkg::ST_RESET;
            sys_reset_r <= RST_OUT_INIT;
            low_line_r <= sswd_pkg::LOW_LINE_RESET_VAL;
            activity_prev_r <= sswd_pkg::ACTIVITY_RESET_VAL;
        end else begin
            state_r <= state_nxt;
            sys_reset_r <= sys_reset_nxt;
            low_line_r <= low_line_nxt;
            activity_prev_r <= activity_prev_nxt;
        end
    end

    assign o_sys_reset = sys_reset_r;
    assign o_low_line_warning = low_line_r;

    // ==========================================================
    // assertions
    // ==========================================================
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);

    localparam logic ASSERTED_LVL = RESET_ACTIVE_HIGH;

    // cycles spent running with no activity edge
    logic [W-1:0] quiet_cnt_r;
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            quiet_cnt_r <= '0;
        end else if (state_r != sswd_pkg::ST_RUN || activity_edge) begin
            quiet_cnt_r <= '0;
        end else begin
            quiet_cnt_r <= quiet_cnt_r + W'(1);
        end
    end

    sequence s_supply_low;
        !i_supply_ok;
    endsequence

    sequence s_hold_expires;
        (state_r == sswd_pkg::ST_HOLD) && hold_done && i_supply_ok;
    endsequence

    sequence s_wd_trip;
        (state_r == sswd_pkg::ST_RUN) && wd_done && i_supply_ok;
    endsequence

    sequence s_wd_hold_expires;
        (state_r == sswd_pkg::ST_WDHOLD) && hold_done && i_supply_ok;
    endsequence

    a_supply_low_reset: assert property (s_supply_low |=> o_sys_reset == ASSERTED_LVL)
        else $error("reset not asserted after supply low");

    a_hold_release: assert property (s_hold_expires |=> o_sys_reset != ASSERTED_LVL ##0 wd_count == '0)
        else $error("reset not released after hold period");

    a_no_early_release: assert property ($rose(state_r == sswd_pkg::ST_RUN) |-> $past(hold_count) == W'(RESET_CYCLES))
        else $error("reset released before hold period ended");

    a_output_polarity: assert property (o_sys_reset == reset_level(reset_asserted(state_r)))
        else $error("reset pin level does not match state and polarity");

    a_low_line_fall: assert property (!i_above_low_line |=> !o_low_line_warning)
        else $error("low-line warning not driven low");

    a_low_line_rise: assert property ($rose(o_low_line_warning) |-> $past(i_above_low_line_hyst) && $past(i_above_low_line))
        else $error("low-line warning released without hysteresis margin");

    // a second edge right behind the first clears again, so it is excused one cycle on
    a_activity_clears: assert property ((state_r == sswd_pkg::ST_RUN) && activity_edge && i_supply_ok |=> wd_count == '0 ##1 (wd_count == W'(1) || state_r != sswd_pkg::ST_RUN || $past(activity_edge)))
        else $error("activity edge did not clear watchdog counter");

    a_wd_trip_reset: assert property (s_wd_trip |=> (state_r == sswd_pkg::ST_WDHOLD) && o_sys_reset == ASSERTED_LVL)
        else $error("watchdog expiry did not assert reset");

    a_wd_period_bound: assert property ((state_r == sswd_pkg::ST_RUN) |-> quiet_cnt_r <= W'(WD_CYCLES))
        else $error("watchdog ran past its period");

    a_wd_hold_restart: assert property (s_wd_hold_expires |=> (state_r == sswd_pkg::ST_RUN) && wd_count == '0 ##1 (wd_count == W'(1) || $past(activity_edge) || state_r != sswd_pkg::ST_RUN))
        else $error("watchdog not restarted after watchdog reset");

    // inside the hysteresis band the warning keeps whatever level it had
    a_low_line_keep: assert property (i_above_low_line && !i_above_low_line_hyst |=> o_low_line_warning == $past(o_low_line_warning))
        else $error("low-line warning moved inside the hysteresis band");

endmodule : sswd_supervisor

//--- verification/sswd_cpu_model.sv
// ==========================================================
// processor stand-in: drives the watchdog activity line
// ==========================================================
module sswd_cpu_model (
    input wire logic i_clk,
    input wire logic i_in_reset,
    input wire logic i_hang,
    input wire logic [7:0] i_gap,
    output logic o_activity
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [7:0] cnt_r = 8'h00;

    initial o_activity = 1'b0;

    // toggle every i_gap+1 cycles; a hung or reset processor leaves the line still
    always @(posedge i_clk) begin
        if (i_in_reset || i_hang) begin
            cnt_r <= 8'h00;
        end else if (cnt_r >= i_gap) begin
            cnt_r <= 8'h00;
            o_activity <= ~o_activity;
        end else begin
            cnt_r <= cnt_r + 8'h01;
        end
    end
endmodule : sswd_cpu_model

//--- verification/tb_supply_supervisor_watchdog.sv
module tb_supply_supervisor_watchdog;
    timeunit 1ns;
    timeprecision 1ns;

    // short counts keep the run brief; expectations derive from these
    localparam int RST_C = 20;
    localparam int WD_C = 40;

    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_supply_ok = 1'b0;
    logic i_above_low_line = 1'b0;
    logic i_above_low_line_hyst = 1'b0;
    logic hang = 1'b0;
    logic [7:0] gap = 8'h05;
    logic activity;
    logic o_sys_reset;
    logic o_low_line_warning;
    logic rst_hi;
    logic exp_ll;
    logic ll_above;
    logic ll_hyst;
    int errors = 0;
    int num_checks = 0;
    int n;

    sswd_supervisor #(.RESET_ACTIVE_HIGH(1'b0), .WD_CYCLES(WD_C), .RESET_CYCLES(RST_C)) dut_u (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_supply_ok(i_supply_ok),
        .i_above_low_line(i_above_low_line), .i_above_low_line_hyst(i_above_low_line_hyst),
        .i_watchdog_activity_input(activity), .o_sys_reset(o_sys_reset),
        .o_low_line_warning(o_low_line_warning));

    // second build with the opposite reset polarity, same stimulus
    sswd_supervisor #(.RESET_ACTIVE_HIGH(1'b1), .WD_CYCLES(WD_C), .RESET_CYCLES(RST_C)) dut_hi (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_supply_ok(i_supply_ok),
        .i_above_low_line(i_above_low_line), .i_above_low_line_hyst(i_above_low_line_hyst),
        .i_watchdog_activity_input(activity), .o_sys_reset(rst_hi),
        .o_low_line_warning());

    sswd_cpu_model cpu_u (
        .i_clk(i_clk), .i_in_reset(o_sys_reset === 1'b0), .i_hang(hang),
        .i_gap(gap), .o_activity(activity));

    initial begin
        forever #50 i_clk = ~i_clk;
    end

    // ==========================================================
    // checking and waiting helpers
    // ==========================================================
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    // count edges until reset reaches lvl; a spent bound ends the run
    task automatic wait_rst(input logic lvl, output int cnt);
        cnt = 0;
        while (o_sys_reset !== lvl) begin
            @(posedge i_clk);
            #1;
            cnt++;
            if (cnt > 200) begin
                errors++;
                conclude();
            end
        end
    endtask : wait_rst

    // ==========================================================
    // main sequence
    // ==========================================================
    initial begin
        n = $urandom(32'h2F214C68);
        repeat (3) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        #1;
        check(o_sys_reset, 1'b0);
        check(rst_hi, 1'b1);
        // power-up: held strictly longer than the timeout
        @(posedge i_clk);
        i_supply_ok <= 1'b1;
        #1;
        wait_rst(1'b1, n);
        check(n >= RST_C + 1 && n <= RST_C + 3, 1'b1);
        check(rst_hi, 1'b0);
        $display("test power_up done");
        // random activity gaps, all inside the period
        repeat (8) begin
            gap <= 8'($urandom_range(30, 0));
            repeat (WD_C) @(posedge i_clk);
        end
        gap <= 8'h00;
        repeat (3) @(posedge i_clk);
        #1;
        check(o_sys_reset, 1'b1);
        $display("test keep_alive done");
        // processor hangs: trip, hold, then the counter restarts from zero
        @(posedge i_clk);
        hang <= 1'b1;
        #1;
        wait_rst(1'b0, n);
        check(n >= WD_C - 1 && n <= WD_C + 3, 1'b1);
        // factory period options at 10 cycles per microsecond
        check(sswd_pkg::wd_period_cycles(0), 32'h0000F230);
        check(sswd_pkg::wd_period_cycles(1), 32'h000F9060);
        check(sswd_pkg::wd_period_cycles(2), 32'h00F42400);
        check(sswd_pkg::wd_period_cycles(3), 32'h0F424000);
        check(rst_hi, 1'b1);
        wait_rst(1'b1, n);
        check(n >= RST_C + 1 && n <= RST_C + 3, 1'b1);
        wait_rst(1'b0, n);
        check(n >= WD_C && n <= WD_C + 3, 1'b1);
        $display("test watchdog done");
        // brownout during hold, then during running
        @(posedge i_clk);
        hang <= 1'b0;
        i_supply_ok <= 1'b0;
        repeat (4) @(posedge i_clk);
        i_supply_ok <= 1'b1;
        repeat (RST_C - 5) @(posedge i_clk);
        i_supply_ok <= 1'b0;
        repeat (3) @(posedge i_clk);
        #1;
        check(o_sys_reset, 1'b0);
        @(posedge i_clk);
        i_supply_ok <= 1'b1;
        #1;
        wait_rst(1'b1, n);
        check(n >= RST_C + 1 && n <= RST_C + 3, 1'b1);
        @(posedge i_clk);
        i_supply_ok <= 1'b0;
        #1;
        wait_rst(1'b0, n);
        check(n <= 2, 1'b1);
        $display("test brownout done");
        // low-line with hysteresis: random comparator pairs, physically ordered
        exp_ll = 1'b0;
        repeat (60) begin
            @(posedge i_clk);
            ll_above = 1'($urandom_range(1, 0));
            // the hysteresis comparator can only trip above the plain one
            ll_hyst = ll_above & 1'($urandom_range(1, 0));
            i_above_low_line <= ll_above;
            i_above_low_line_hyst <= ll_hyst;
            if (!ll_above) begin
                exp_ll = 1'b0;
            end else if (ll_hyst) begin
                exp_ll = 1'b1;
            end
            repeat (3) @(posedge i_clk);
            #1;
            check(o_low_line_warning, exp_ll);
        end
        $display("test low_line done");
        conclude();
    end
endmodule : tb_supply_supervisor_watchdog
